// ### bench/csfr_chk.sv
// concurrent checks on the flag register ports
`timescale 1ns/1ps
`default_nettype none
module csfr_chk (
  input wire logic mclk, // clock
  input wire logic reset_n, // reset, active low
  input wire csfr_pkg::csfr_alu_s alu_in, // alu result
  input wire logic insn_wr_valid, // instruction write
  input wire logic wdog_clear, // watchdog clear
  input wire logic sleep_entry, // sleep entry
  input wire logic wdog_expire, // watchdog expiry
  input wire logic s_axi_awvalid, // bus write address valid
  input wire logic s_axi_wvalid, // bus write data valid
  input wire logic [7:0] flags_out // flag register
);
  logic [8:0] sum;
  logic ev;
  logic add;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  assign sum = {1'b0, alu_in.op_a} + {1'b0, alu_in.op_b};
  assign ev = wdog_clear | sleep_entry | wdog_expire;
  assign add = alu_in.valid & !alu_in.is_sub & !alu_in.is_rotate;
  a_top_zero: assert property (flags_out[7:6] == 2'h0)
    else $error("unused bits set");
  a_sys_hold: assert property (!ev |=> $stable(flags_out[5:4]))
    else $error("system flags moved");
  a_wdog_set: assert property
    (wdog_expire && !wdog_clear && !sleep_entry |=> flags_out[5])
    else $error("expiry not recorded");
  a_wdog_clr: assert property
    (wdog_clear || sleep_entry |=> !flags_out[5])
    else $error("expiry flag not cleared");
  a_pd_set: assert property
    (sleep_entry && !wdog_clear |=> flags_out[4])
    else $error("power down not set");
  a_pd_clr: assert property (wdog_clear |=> !flags_out[4])
    else $error("power down not cleared");
  a_add_carry: assert property
    (add && alu_in.sel.borrow_out |=> flags_out[0] == $past(sum[8]))
    else $error("add carry wrong");
  a_rot_carry: assert property
    (alu_in.valid && alu_in.is_rotate && alu_in.sel.borrow_out
      |=> flags_out[0] == $past(alu_in.rotate_out))
    else $error("rotate carry wrong");
  a_zero_flag: assert property
    (alu_in.valid && alu_in.sel.null_result
      |=> flags_out[2] == ($past(alu_in.result) == 8'h00))
    else $error("zero flag wrong");
  a_arith_keep: assert property
    (!alu_in.valid && !insn_wr_valid && !s_axi_awvalid && !s_axi_wvalid
      |=> $stable(flags_out[3:0]))
    else $error("arithmetic flags moved");
endmodule
bind csfr_flag_reg csfr_chk i_csfr_chk (.mclk, .reset_n, .alu_in,
  .insn_wr_valid, .wdog_clear, .sleep_entry, .wdog_expire,
  .s_axi_awvalid, .s_axi_wvalid, .flags_out);
`default_nettype wire

// ### bench/csfr_core_model.sv
// behavioural alu and sequencer feeding the flag register
`timescale 1ns/1ps
`default_nettype none
module csfr_core_model (
  input wire logic mclk, // clock
  input wire logic go, // launch one operation
  input wire logic rot, // shift left, bit 7 out to carry, zero into bit 0
  input wire logic sub, // subtract, else add
  input wire logic [7:0] a, // first operand
  input wire logic [7:0] b, // second operand
  output var csfr_pkg::csfr_alu_s alu // result to the flag register
);
  // one operation per go, valid for a single cycle
  always_ff @(posedge mclk)
  begin
    alu <= '0;
    if (go)
    begin
      alu.valid <= 1'b1;
      alu.sel <= rot ? 4'h8 : 4'hf;
      alu.is_sub <= sub;
      alu.is_rotate <= rot;
      alu.rotate_out <= a[7];
      alu.op_a <= a;
      alu.op_b <= b;
      alu.result <= rot ? {a[6:0], 1'b0} : (sub ? a - b : a + b);
    end
  end
endmodule
`default_nettype wire

// ### bench/test_cpu_status_flag_register.sv
// self-checking bench for the cpu status flag register
`timescale 1ns/1ps
`default_nettype none
module test_cpu_status_flag_register;
  logic mclk = 1'b0, reset_n = 1'b0, go = 1'b0, rot = 1'b0, sub = 1'b0;
  logic [7:0] a = 8'h00, b = 8'h00, insn_wr_data = 8'hfa;
  logic insn_wr_valid = 1'b0, wdog_clear = 1'b0, sleep_entry = 1'b0;
  logic wdog_expire = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, ex;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [7:0] flags_out;
  csfr_pkg::csfr_alu_s alu_in;
  int num_errors = 0;
  int comparisons = 0;
  always #50 mclk = ~mclk;
  csfr_core_model i_csfr_core_model (.mclk, .go, .rot, .sub, .a, .b,
    .alu(alu_in));
  csfr_flag_reg i_csfr_flag_reg (.mclk, .reset_n, .alu_in, .insn_wr_valid,
    .insn_wr_data, .wdog_clear, .sleep_entry, .wdog_expire, .flags_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // bready and rready stay high, so each wait ends at the answer edge
  task automatic wr(input logic [3:0] ad, input logic [7:0] d,
    input logic [1:0] er);
    int n;
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // always pass one edge: the previous answer may still show at entry
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    ck(n < 20, 1'b1);
    if (n >= 20) test_done();
    ck(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] d,
    input logic [1:0] er);
    int n;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    ck(n < 20, 1'b1);
    if (n >= 20) test_done();
    ck(s_axi_rdata, {24'h00_0000, d});
    ck(s_axi_rresp, er);
  endtask
  task automatic op(input logic r, s, input logic [7:0] x, y);
    logic [7:0] yy;
    logic [8:0] t;
    logic [4:0] h;
    yy = s ? ~y : y;
    t = x + yy + s;
    h = x[3:0] + yy[3:0] + s;
    if (r)
      ex[0] = x[7];
    else
      ex = {x[7] == yy[7] && t[7] != x[7], t[7:0] == 8'h00, h[4], t[8]};
    rot <= r;
    sub <= s;
    a <= x;
    b <= y;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
    ck(flags_out[3:0], ex);
  endtask
  task automatic ev(input logic e, c, s, w, input logic [1:0] x);
    wdog_expire <= e;
    wdog_clear <= c;
    sleep_entry <= s;
    insn_wr_valid <= w;
    tick(1);
    wdog_expire <= 1'b0;
    wdog_clear <= 1'b0;
    sleep_entry <= 1'b0;
    insn_wr_valid <= 1'b0;
    tick(1);
    ck(flags_out[5:4], x);
  endtask
  task automatic t_arith();
    logic [16:0] tv [5] = '{17'h0_ff01, 17'h0_7f01, 17'h1_0503,
      17'h1_0305, 17'h1_8001};
    foreach (tv[i])
      op(1'b0, tv[i][16], tv[i][15:8],
        tv[i][7:0]);
    op(1'b1, 1'b0, 8'h80, 8'h00);
    op(1'b1, 1'b0, 8'h01, 8'h00);
  endtask
  task automatic t_sys();
    wr(csfr_pkg::ADDR_IRQ_MASK, 8'h00, csfr_pkg::RESP_OKAY);
    ev(1'b1, 1'b0, 1'b0, 1'b0, 2'h2);
    ck(irq, 1'b0);
    wr(csfr_pkg::ADDR_IRQ_MASK, 8'h07, csfr_pkg::RESP_OKAY);
    ck(irq, 1'b1);
    rd(csfr_pkg::ADDR_IRQ_STATUS, 8'h01, csfr_pkg::RESP_OKAY);
    ev(1'b0, 1'b0, 1'b1, 1'b0, 2'h1);
    ev(1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
    ev(1'b0, 1'b0, 1'b0, 1'b1, 2'h3);
    ck(flags_out[3:0], 4'ha);
    wr(csfr_pkg::ADDR_FLAGS, 8'hf5, csfr_pkg::RESP_OKAY);
    rd(csfr_pkg::ADDR_FLAGS, 8'h35,
      csfr_pkg::RESP_OKAY);
    rd(csfr_pkg::ADDR_IRQ_STATUS, 8'h07, csfr_pkg::RESP_OKAY);
    rd(csfr_pkg::ADDR_IRQ_MASK, 8'h07, csfr_pkg::RESP_OKAY);
    wr(csfr_pkg::ADDR_IRQ_STATUS, 8'h07, csfr_pkg::RESP_OKAY);
    rd(csfr_pkg::ADDR_IRQ_STATUS, 8'h00, csfr_pkg::RESP_OKAY);
    ck(irq, 1'b0);
    ev(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
  endtask
  task automatic t_save();
    rd(csfr_pkg::ADDR_FLAGS, 8'h05, csfr_pkg::RESP_OKAY);
    op(1'b0, 1'b0, 8'hff, 8'h01);
    wr(csfr_pkg::ADDR_FLAGS, 8'h05, csfr_pkg::RESP_OKAY);
    rd(csfr_pkg::ADDR_FLAGS, 8'h05, csfr_pkg::RESP_OKAY);
    // lane 0 disabled: the write is answered but must not land
    s_axi_wstrb <= 4'he;
    wr(csfr_pkg::ADDR_FLAGS, 8'h0a, csfr_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(csfr_pkg::ADDR_FLAGS, 8'h05, csfr_pkg::RESP_OKAY);
    wr(4'hc, 8'hff, csfr_pkg::RESP_SLVERR);
    rd(4'hc, 8'h00, csfr_pkg::RESP_SLVERR);
  endtask
  task automatic t_reset();
    ev(1'b0, 1'b0, 1'b1, 1'b0, 2'h1);
    ev(1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    ck(flags_out[7:4], 4'h0);
    tick(1);
    rd(csfr_pkg::ADDR_IRQ_STATUS, 8'h00, csfr_pkg::RESP_OKAY);
  endtask
  initial
  begin
    tick(2);
    reset_n <= 1'b1;
    ck(flags_out, 8'h00);
    rd(csfr_pkg::ADDR_FLAGS, 8'h00, csfr_pkg::RESP_OKAY);
    t_arith();
    t_sys();
    t_save();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire

// ### hdl/csfr_flag_reg.sv
// cpu status flag register with axi4-lite access and event interrupt
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - bits 7 and 6 are unimplemented and always read zero.
// - a data write leaves watchdog and power-down flags untouched.
// - watchdog bit cleared by reset, watchdog clear or sleep; set on expiry.
// - power-down bit cleared by reset or watchdog clear; set by sleep.
// - carry bit set on add carry or subtract without borrow.
// - rotate through carry loads carry bit with the bit shifted out.
// - nibble carry set on low nibble carry or no nibble borrow.
// - zero bit set when the operation result is zero.
// - overflow set when carry into msb differs from carry out.
// - system flags reset to zero; arithmetic flags software writable.
module csfr_flag_reg (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async power-up reset, active low
  input wire csfr_pkg::csfr_alu_s alu_in, // alu result and flag selects
  input wire logic insn_wr_valid, // instruction writes the flag register
  input wire logic [7:0] insn_wr_data, // data of that write
  input wire logic wdog_clear, // watchdog clear instruction executed
  input wire logic sleep_entry, // sleep entry instruction executed
  input wire logic wdog_expire, // watchdog timer expired
  output logic [7:0] flags_out, // current flag register value
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic irq // level interrupt, unmasked event pending
);

  logic [3:0] arith_q;
  logic pd_q;
  logic wd_q;
  logic [csfr_pkg::EVT_NUM-1:0] irq_status_q;
  logic [csfr_pkg::EVT_NUM-1:0] irq_mask_q;
  logic aw_held_q;
  logic w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // alu flag arithmetic
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [7:0] opb_eff;
  logic cin;
  logic carry_out;
  logic nib_carry;
  logic carry_msb_in;

  // subtraction done as a + ~b + 1, so carry out means no borrow
  assign opb_eff = alu_in.is_sub ? ~alu_in.op_b : alu_in.op_b;
  assign cin = alu_in.is_sub;
  assign sum9 = {1'b0, alu_in.op_a} + {1'b0, opb_eff} + {8'h00, cin};
  assign sum5 = {1'b0, alu_in.op_a[3:0]} + {1'b0, opb_eff[3:0]} +
                {4'h0, cin};
  assign sum7 = {1'b0, alu_in.op_a[6:0]} + {1'b0, opb_eff[6:0]} +
                {7'h00, cin};
  assign carry_out = sum9[8];
  assign nib_carry = sum5[4];
  assign carry_msb_in = sum7[7];

  // write channel fire, both halves present
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  assign wr_fire = (aw_held_q | s_axi_awvalid) & (w_held_q | s_axi_wvalid) &
                   ~bvalid_q;
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;

  logic sw_flag_wr;
  logic sw_stat_wr;
  logic sw_mask_wr;
  logic addr_ok;
  assign addr_ok = (wr_addr == csfr_pkg::ADDR_FLAGS) ||
                   (wr_addr == csfr_pkg::ADDR_IRQ_STATUS) ||
                   (wr_addr == csfr_pkg::ADDR_IRQ_MASK);
  assign sw_flag_wr = wr_fire & wr_lane0 &
                      (wr_addr == csfr_pkg::ADDR_FLAGS);
  assign sw_stat_wr = wr_fire & wr_lane0 &
                      (wr_addr == csfr_pkg::ADDR_IRQ_STATUS);
  assign sw_mask_wr = wr_fire & wr_lane0 &
                      (wr_addr == csfr_pkg::ADDR_IRQ_MASK);

  // write-address and write-data holding
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // write response
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= csfr_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_ok ? csfr_pkg::RESP_OKAY : csfr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // arithmetic flags: software write, then instruction write, then alu;
  // alu outcome wins since it is the latest operation in that cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arith_q <= csfr_pkg::FLAGS_RESET[3:0];
    end
    else if (alu_in.valid)
    begin
      if (alu_in.sel.borrow_out)
      begin
        arith_q[csfr_pkg::BIT_BORROW_OUT] <= alu_in.is_rotate ?
          alu_in.rotate_out : carry_out;
      end
      if (alu_in.sel.nibble_carry)
      begin
        arith_q[csfr_pkg::BIT_NIBBLE_CARRY] <= nib_carry;
      end
      if (alu_in.sel.null_result)
      begin
        arith_q[csfr_pkg::BIT_NULL_RESULT] <=
          (alu_in.result == 8'h00);
      end
      if (alu_in.sel.signed_wrap)
      begin
        arith_q[csfr_pkg::BIT_SIGNED_WRAP] <=
          carry_msb_in ^ carry_out;
      end
      // unselected flags hold
    end
    else if (insn_wr_valid)
    begin
      arith_q <= insn_wr_data[3:0];
    end
    else if (sw_flag_wr)
    begin
      arith_q <= wr_data[3:0];
    end
  end

  // system flags: never written by data writes
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pd_q <= 1'b0;
      wd_q <= 1'b0;
    end
    else
    begin
      if (wdog_clear || sleep_entry)
      begin
        wd_q <= 1'b0;
      end
      else if (wdog_expire)
      begin
        wd_q <= 1'b1;
      end
      if (wdog_clear)
      begin
        pd_q <= 1'b0;
      end
      else if (sleep_entry)
      begin
        pd_q <= 1'b1;
      end
    end
  end

  // unimplemented upper bits are constant zero; each field has one driver
  always_comb
  begin
    flags_out = 8'h00;
    flags_out[3:0] = arith_q;
    flags_out[csfr_pkg::BIT_POWER_DOWN] = pd_q;
    flags_out[csfr_pkg::BIT_WDOG_EXPIRED] = wd_q;
  end

  // interrupt events; set wins over a clear in the same cycle
  logic [csfr_pkg::EVT_NUM-1:0] evt;
  assign evt[csfr_pkg::EVT_WDOG] = wdog_expire;
  assign evt[csfr_pkg::EVT_SLEEP] = sleep_entry;
  assign evt[csfr_pkg::EVT_WRITE] = insn_wr_valid;

  genvar gi;
  generate
    for (gi = 0; gi < csfr_pkg::EVT_NUM; gi++)
    begin : g_evt
      logic st_q;
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          st_q <= 1'b0;
        end
        else if (evt[gi])
        begin
          st_q <= 1'b1;
        end
        else if (sw_stat_wr && wr_data[gi])
        begin
          st_q <= 1'b0;
        end
      end
      assign irq_status_q[gi] = st_q;
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_mask_q <= csfr_pkg::EVT_RESET;
    end
    else if (sw_mask_wr)
    begin
      irq_mask_q <= wr_data[csfr_pkg::EVT_NUM-1:0];
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // read channel, one read outstanding
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= csfr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= csfr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        csfr_pkg::ADDR_FLAGS:
          rdata_q <= {24'h00_0000, flags_out};
        csfr_pkg::ADDR_IRQ_STATUS:
          rdata_q <= {29'h0000_0000, irq_status_q};
        csfr_pkg::ADDR_IRQ_MASK:
          rdata_q <= {29'h0000_0000, irq_mask_q};
        default:
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= csfr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

// ### hdl/csfr_pkg.sv
// package for the cpu status flag register block
package csfr_pkg;

  // register offsets on the axi4-lite slave
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

  // flag bit positions
  localparam int BIT_BORROW_OUT = 0;
  localparam int BIT_NIBBLE_CARRY = 1;
  localparam int BIT_NULL_RESULT = 2;
  localparam int BIT_SIGNED_WRAP = 3;
  localparam int BIT_POWER_DOWN = 4;
  localparam int BIT_WDOG_EXPIRED = 5;

  // interrupt status bit positions
  localparam int EVT_WDOG = 0;
  localparam int EVT_SLEEP = 1;
  localparam int EVT_WRITE = 2;
  localparam int EVT_NUM = 3;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [EVT_NUM-1:0] EVT_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // which arithmetic flags an alu operation updates
  typedef struct packed {
    logic borrow_out;
    logic nibble_carry;
    logic null_result;
    logic signed_wrap;
  } csfr_flag_sel_s;

  // alu result presented to the flag register
  typedef struct packed {
    logic valid;
    csfr_flag_sel_s sel;
    logic is_sub;
    logic is_rotate;
    logic rotate_out;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [7:0] result;
  } csfr_alu_s;

endpackage
